/* rtl/crg_cpu_regs.sv */
// Design decisions made here: the strobed register port and the register addresses.
`timescale 1ns/1ps
`include "crg_params.svh"
// Behaviour
// - peripheral register area is FF00H through FFFFH
// - special data addressing from FE00H small RAM, FD00H large RAM
// - fetch pointer is a 16-bit next-instruction address
// - sequential execution advances fetch pointer by instruction length
// - branch loads immediate target or selected register contents
// - reset loads fetch pointer from vector bytes 0000H and 0001H
// - even vector byte is low half, odd byte high half
// - flag word is 8 bits, reset value 02H
// - flags pushed on interrupt and push-flags, restored on return/pop-flags
// - accept flag clear refuses all maskable requests, not non-maskable
// - accept flag set lets each source's mask govern
// - mask-all and acknowledge clear accept flag, unmask-all sets it
// - null flag set on zero result, cleared otherwise
// - nibble carry set on carry or borrow at bit 3
// - main carry holds add and subtract overflow or underflow
// - main carry takes rotate shift-out and acts as bit accumulator
// - stack pointer 16 bits, only internal RAM valid
// - stack pointer decrements before push, increments after pop
// - eight 8-bit general registers, indexed zero to seven
// - registers pair into four 16-bit pairs, indexed zero to three
// - peripheral registers allow 1, 8 or 16 bit access; the register port here moves 8 or 16 bits, with no 1-bit access
// - each peripheral register is RW, read-only or write-only, enforced; here only status is read-only, none write-only
module crg_cpu_regs #(
  parameter bit LARGE_RAM = 1'b1,
  parameter int NUM_IRQ = 8
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  // instruction side
  input wire crg_pkg::crg_cmd_t i_cmd,
  input wire crg_pkg::crg_alu_res_t i_alu,
  input wire logic [2:0] i_reg_sel,
  input wire logic i_reg_we,
  input wire logic [7:0] i_reg_wdata,
  // memory read of vector bytes and stack restore
  input wire logic [7:0] i_mem_rdata,
  // interrupts
  input wire logic [NUM_IRQ-1:0] i_irq_req,
  input wire logic [NUM_IRQ-1:0] i_irq_mask,
  input wire logic i_nmi_req,
  input wire logic [15:0] i_irq_vector,
  // memory access and state outputs from this block
  output logic [15:0] o_mem_addr,
  output logic o_mem_rd,
  output logic o_mem_wr,
  output logic [7:0] o_mem_wdata,
  output logic o_irq_ack,
  output logic [15:0] o_fetch_ptr,
  output logic [7:0] o_flags,
  output logic [15:0] o_stack_ptr,
  output logic [7:0] o_reg_rdata,
  output logic o_ready,
  output logic o_stack_fault,
  // decode of a data address
  input wire logic [15:0] i_daddr,
  output logic o_daddr_sfr,
  output logic o_daddr_special,
  // register port
  input wire logic [7:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata
);

  // refused at elaboration: the request vectors are sized from this count
  if (NUM_IRQ < 1 || NUM_IRQ > 16) begin : g_bad_num_irq
    $error("NUM_IRQ out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset release and small helpers

  logic rst_meta_q, rst_sync_q;
  wire logic rstn = rst_sync_q;

  // two flops release the asynchronous reset cleanly
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  function automatic logic in_sfr(input logic [15:0] a);
    in_sfr = (a >= `CRG_SFR_BASE) && (a <= `CRG_SFR_TOP);
  endfunction

  function automatic logic in_ram(input logic [15:0] a);
    logic [15:0] base;
    base = LARGE_RAM ? `CRG_RAM_LARGE_BASE : `CRG_RAM_SMALL_BASE;
    in_ram = (a >= base) && (a <= `CRG_RAM_TOP);
  endfunction

  // map decode for the address generator
  always_comb begin
    o_daddr_sfr = in_sfr(i_daddr);
    o_daddr_special = LARGE_RAM ? (i_daddr >= `CRG_DMEM_LARGE_BASE)
                                : (i_daddr >= `CRG_DMEM_SMALL_BASE);
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer: vector fetch after reset, push and pop byte steps

  crg_pkg::crg_state_t state_q;
  logic [15:0] pc_q, sp_q;
  logic [7:0] flags_q;
  logic [7:0] gpr_q [8];
  logic [1:0] push_cnt_q; // bytes still to push after the current one for interrupt entry
  logic irq_busy_q;
  logic pop_pending_q; // pop read issued, data next cycle
  crg_pkg::crg_op_t pop_op_q;
  logic [1:0] ret_step_q;
  logic [7:0] ret_lo_q;
  logic ie_saved_q; // accept flag as it stood before the acknowledge cleared it
  crg_pkg::crg_bus_t bus;
  assign bus = '{wr: i_wr, rd: i_rd, addr: i_addr, wdata: i_wdata};

  wire logic running = (state_q == crg_pkg::CRG_ST_RUN);
  wire logic maskable_hit = flags_q[`CRG_FLAG_IE] && |(i_irq_req & ~i_irq_mask);
  // never taken in the middle of a push, pop or return sequence
  wire logic take_irq = o_ready && (i_nmi_req || maskable_hit);

  assign o_ready = running && !irq_busy_q && !pop_pending_q && ret_step_q == 2'd0;

  // vector fetch: read 0000H then 0001H
  always_ff @(posedge i_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= crg_pkg::CRG_ST_RESET;
    end else begin
      case (state_q)
        crg_pkg::CRG_ST_RESET: state_q <= crg_pkg::CRG_ST_VEC_LO;
        crg_pkg::CRG_ST_VEC_LO: state_q <= crg_pkg::CRG_ST_VEC_HI;
        crg_pkg::CRG_ST_VEC_HI: state_q <= crg_pkg::CRG_ST_RUN;
        default: state_q <= crg_pkg::CRG_ST_RUN;
      endcase
    end
  end

  // memory strobes; stack pushes write at the already-decremented pointer
  logic [7:0] push_byte;
  always_comb begin
    o_mem_addr = 16'h0000;
    o_mem_rd = 1'b0;
    o_mem_wr = 1'b0;
    push_byte = 8'h00;
    if (state_q == crg_pkg::CRG_ST_RESET) begin
      o_mem_addr = `CRG_RESET_VEC_LO;
      o_mem_rd = 1'b1;
    end else if (state_q == crg_pkg::CRG_ST_VEC_LO) begin
      o_mem_addr = `CRG_RESET_VEC_HI;
      o_mem_rd = 1'b1;
    end else if (irq_busy_q) begin
      // flags first, then high and low return address bytes
      o_mem_wr = 1'b1;
      o_mem_addr = 16'(sp_q - 16'h0001);
      case (push_cnt_q)
        2'd2: push_byte = {ie_saved_q, flags_q[6:0]};
        2'd1: push_byte = pc_q[15:8];
        default: push_byte = pc_q[7:0];
      endcase
    end else if (o_ready && (i_cmd.op == crg_pkg::CRG_OP_PUSH
                             || i_cmd.op == crg_pkg::CRG_OP_PUSH_FLAGS)) begin
      o_mem_wr = 1'b1;
      o_mem_addr = 16'(sp_q - 16'h0001);
      push_byte = (i_cmd.op == crg_pkg::CRG_OP_PUSH_FLAGS) ? flags_q : i_cmd.data;
    end else if ((o_ready && (i_cmd.op == crg_pkg::CRG_OP_POP
                  || i_cmd.op == crg_pkg::CRG_OP_POP_FLAGS
                  || i_cmd.op == crg_pkg::CRG_OP_IRQ_RETURN)) || ret_step_q != 2'd0) begin
      o_mem_rd = ret_step_q != 2'd3; // third return byte was read a step earlier
      o_mem_addr = sp_q;
    end
  end

  // write data leaves through a flop; the strobe is paired one cycle earlier
  always_ff @(posedge i_clk or negedge rstn) begin
    if (!rstn) o_mem_wdata <= 8'h00;
    else o_mem_wdata <= push_byte;
  end

  // stack faults: pointer outside internal RAM during interrupt entry, push, push-flags or pop
  always_ff @(posedge i_clk or negedge rstn) begin
    if (!rstn) o_stack_fault <= 1'b0;
    else o_stack_fault <= (o_mem_wr || (o_mem_rd && running)) && !in_ram(o_mem_addr)
                          && (irq_busy_q || i_cmd.op inside {crg_pkg::CRG_OP_PUSH,
                              crg_pkg::CRG_OP_PUSH_FLAGS, crg_pkg::CRG_OP_POP});
  end

  ////////////////////////////////////////////////////////////////////////////
  // fetch pointer

  always_ff @(posedge i_clk or negedge rstn) begin
    if (!rstn) begin
      pc_q <= 16'h0000;
    end else if (state_q == crg_pkg::CRG_ST_VEC_LO) begin
      pc_q[7:0] <= i_mem_rdata;
    end else if (state_q == crg_pkg::CRG_ST_VEC_HI) begin
      pc_q[15:8] <= i_mem_rdata;
    end else if (irq_busy_q && push_cnt_q == 2'd0) begin
      pc_q <= i_irq_vector;
    end else if (ret_step_q == 2'd2) begin
      pc_q <= {i_mem_rdata, ret_lo_q};
    end else if (take_irq) begin
      pc_q <= pc_q;
    end else if (bus.wr && bus.addr == `CRG_REG_FETCH) begin
      pc_q <= bus.wdata;
    end else if (o_ready) begin
      case (i_cmd.op)
        crg_pkg::CRG_OP_SEQ: pc_q <= 16'(pc_q + {13'h0000, i_cmd.len});
        crg_pkg::CRG_OP_BR_IMM: pc_q <= i_cmd.target;
        crg_pkg::CRG_OP_BR_REG: pc_q <= {gpr_q[{i_reg_sel[2:1], 1'b1}],
                                         gpr_q[{i_reg_sel[2:1], 1'b0}]};
        default: pc_q <= pc_q;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt entry and return sequencing

  always_ff @(posedge i_clk or negedge rstn) begin
    if (!rstn) begin
      irq_busy_q <= 1'b0;
      push_cnt_q <= 2'd0;
      ie_saved_q <= 1'b0;
    end else if (take_irq) begin
      irq_busy_q <= 1'b1;
      push_cnt_q <= 2'd2;
      ie_saved_q <= flags_q[`CRG_FLAG_IE];
    end else if (irq_busy_q) begin
      if (push_cnt_q == 2'd0) irq_busy_q <= 1'b0;
      else push_cnt_q <= push_cnt_q - 2'd1;
    end
  end

  assign o_irq_ack = take_irq;

  // return pops low address byte, high byte, then flags
  always_ff @(posedge i_clk or negedge rstn) begin
    if (!rstn) begin
      ret_step_q <= 2'd0;
      ret_lo_q <= 8'h00;
      pop_pending_q <= 1'b0;
      pop_op_q <= crg_pkg::CRG_OP_NONE;
    end else begin
      pop_pending_q <= 1'b0;
      if (o_ready && i_cmd.op inside {crg_pkg::CRG_OP_POP, crg_pkg::CRG_OP_POP_FLAGS}) begin
        pop_pending_q <= 1'b1;
        pop_op_q <= i_cmd.op;
      end
      if (o_ready && i_cmd.op == crg_pkg::CRG_OP_IRQ_RETURN) ret_step_q <= 2'd1;
      else if (ret_step_q == 2'd1) begin
        ret_lo_q <= i_mem_rdata;
        ret_step_q <= 2'd2;
      end else if (ret_step_q == 2'd2) ret_step_q <= 2'd3;
      else if (ret_step_q == 2'd3) ret_step_q <= 2'd0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // stack pointer, left at zero here though software must load it

  wire logic sp_dec = o_mem_wr;
  wire logic sp_inc = o_mem_rd && running && (ret_step_q != 2'd0 || o_ready);

  always_ff @(posedge i_clk or negedge rstn) begin
    if (!rstn) sp_q <= 16'h0000;
    else if (bus.wr && bus.addr == `CRG_REG_STACK) sp_q <= bus.wdata;
    else if (sp_dec) sp_q <= 16'(sp_q - 16'h0001);
    else if (sp_inc) sp_q <= 16'(sp_q + 16'h0001);
  end

  ////////////////////////////////////////////////////////////////////////////
  // flag word

  always_ff @(posedge i_clk or negedge rstn) begin
    if (!rstn) begin
      flags_q <= `CRG_FLAGS_RESET;
    end else if (take_irq) begin
      flags_q[`CRG_FLAG_IE] <= 1'b0;
    end else if (ret_step_q == 2'd3 || (pop_pending_q && pop_op_q == crg_pkg::CRG_OP_POP_FLAGS)) begin
      flags_q <= i_mem_rdata;
    end else if (bus.wr && bus.addr == `CRG_REG_FLAGS) begin
      flags_q <= bus.wdata[7:0];
    end else if (o_ready) begin
      if (i_cmd.op == crg_pkg::CRG_OP_MASK_ALL) flags_q[`CRG_FLAG_IE] <= 1'b0;
      if (i_cmd.op == crg_pkg::CRG_OP_UNMASK) flags_q[`CRG_FLAG_IE] <= 1'b1;
      if (i_alu.kind != crg_pkg::CRG_ALU_NONE) begin
        flags_q[`CRG_FLAG_Z] <= (i_alu.result == 8'h00);
      end
      if (i_alu.kind == crg_pkg::CRG_ALU_ADD || i_alu.kind == crg_pkg::CRG_ALU_SUB) begin
        flags_q[`CRG_FLAG_AC] <= i_alu.nib_carry;
        flags_q[`CRG_FLAG_CY] <= i_alu.carry;
      end
      if (i_alu.kind == crg_pkg::CRG_ALU_ROT || i_alu.kind == crg_pkg::CRG_ALU_BIT) begin
        flags_q[`CRG_FLAG_CY] <= i_alu.carry;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // general registers: 8 bytes, pairs are two adjacent bytes

  always_ff @(posedge i_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 8; i++) gpr_q[i] <= 8'h00;
    end else if (pop_pending_q && pop_op_q == crg_pkg::CRG_OP_POP) begin
      gpr_q[i_reg_sel] <= i_mem_rdata;
    end else if (bus.wr && bus.addr[7:3] == 5'(`CRG_REG_GPR0 >> 3)) begin
      gpr_q[bus.addr[2:0]] <= bus.wdata[7:0];
    end else if (bus.wr && bus.addr[7:2] == 6'(`CRG_REG_PAIR0 >> 2)) begin
      gpr_q[{bus.addr[1:0], 1'b0}] <= bus.wdata[7:0];
      gpr_q[{bus.addr[1:0], 1'b1}] <= bus.wdata[15:8];
    end else if (i_reg_we) begin
      gpr_q[i_reg_sel] <= i_reg_wdata;
    end
  end

  always_ff @(posedge i_clk or negedge rstn) begin
    if (!rstn) o_reg_rdata <= 8'h00;
    else o_reg_rdata <= gpr_q[i_reg_sel];
  end

  always_ff @(posedge i_clk or negedge rstn) begin
    if (!rstn) begin
      o_fetch_ptr <= 16'h0000;
      o_flags <= 8'h00;
      o_stack_ptr <= 16'h0000;
    end else begin
      o_fetch_ptr <= pc_q;
      o_flags <= flags_q;
      o_stack_ptr <= sp_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register port read, one cycle after the strobe

  always_ff @(posedge i_clk or negedge rstn) begin
    if (!rstn) begin
      o_rdata <= 16'h0000;
    end else if (bus.rd) begin
      if (bus.addr == `CRG_REG_FETCH) o_rdata <= pc_q;
      else if (bus.addr == `CRG_REG_FLAGS) o_rdata <= {8'h00, flags_q};
      else if (bus.addr == `CRG_REG_STACK) o_rdata <= sp_q;
      else if (bus.addr[7:3] == 5'(`CRG_REG_GPR0 >> 3)) o_rdata <= {8'h00, gpr_q[bus.addr[2:0]]};
      else if (bus.addr[7:2] == 6'(`CRG_REG_PAIR0 >> 2))
        o_rdata <= {gpr_q[{bus.addr[1:0], 1'b1}], gpr_q[{bus.addr[1:0], 1'b0}]};
      else if (bus.addr == `CRG_REG_STATUS)
        o_rdata <= {12'h000, irq_busy_q, o_ready, state_q}; // read-only, no write path
      else o_rdata <= 16'h0000;
    end else begin
      o_rdata <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  sequence vec_fetch_s;
    state_q == crg_pkg::CRG_ST_VEC_LO ##1 state_q == crg_pkg::CRG_ST_VEC_HI;
  endsequence

  vector_load_a: assert property (@(posedge i_clk) disable iff (!rstn)
    vec_fetch_s |=> pc_q == {$past(i_mem_rdata), $past(i_mem_rdata, 2)})
    else $error("reset vector not assembled low then high");

  seq_advance_a: assert property (@(posedge i_clk) disable iff (!rstn)
    o_ready && !take_irq && !bus.wr && i_cmd.op == crg_pkg::CRG_OP_SEQ
      |=> pc_q == 16'($past(pc_q) + {13'h0000, $past(i_cmd.len)}))
    else $error("fetch pointer did not advance by length");

  branch_imm_a: assert property (@(posedge i_clk) disable iff (!rstn)
    o_ready && !take_irq && !bus.wr && i_cmd.op == crg_pkg::CRG_OP_BR_IMM
      |=> pc_q == $past(i_cmd.target))
    else $error("branch target not loaded");

  ie_mask_a: assert property (@(posedge i_clk) disable iff (!rstn)
    !flags_q[`CRG_FLAG_IE] && !i_nmi_req |-> !o_irq_ack)
    else $error("maskable request taken while masked");

  ack_clear_a: assert property (@(posedge i_clk) disable iff (!rstn)
    o_irq_ack |=> !flags_q[`CRG_FLAG_IE] ##3 pc_q == $past(i_irq_vector))
    else $error("acknowledge did not clear accept flag or load vector");

  zero_flag_a: assert property (@(posedge i_clk) disable iff (!rstn)
    o_ready && !take_irq && !bus.wr && i_alu.kind == crg_pkg::CRG_ALU_ADD
      && !(ret_step_q == 2'd3) |=> flags_q[`CRG_FLAG_Z] == ($past(i_alu.result) == 8'h00))
    else $error("null flag wrong");

  push_dec_a: assert property (@(posedge i_clk) disable iff (!rstn)
    o_mem_wr && !bus.wr |-> o_mem_addr == 16'(sp_q - 16'h0001) ##1 sp_q == $past(o_mem_addr))
    else $error("stack pointer not pre-decremented");

  irq_push_a: assert property (@(posedge i_clk) disable iff (!rstn)
    o_irq_ack |=> o_mem_wr [*3])
    else $error("interrupt entry did not push three bytes");

endmodule

/* rtl/crg_params.svh */
`ifndef CRG_PARAMS_SVH
`define CRG_PARAMS_SVH
// address map
`define CRG_SFR_BASE 16'hFF00
`define CRG_SFR_TOP 16'hFFFF
`define CRG_DMEM_SMALL_BASE 16'hFE00
`define CRG_DMEM_LARGE_BASE 16'hFD00
`define CRG_RAM_SMALL_BASE 16'hFE00
`define CRG_RAM_LARGE_BASE 16'hFD00
`define CRG_RAM_TOP 16'hFEFF
`define CRG_RESET_VEC_LO 16'h0000
`define CRG_RESET_VEC_HI 16'h0001
// flag word
`define CRG_FLAGS_RESET 8'h02
`define CRG_FLAG_CY 0
`define CRG_FLAG_AC 4
`define CRG_FLAG_Z 6
`define CRG_FLAG_IE 7
// register port offsets
`define CRG_REG_FETCH 8'h00
`define CRG_REG_FLAGS 8'h01
`define CRG_REG_STACK 8'h02
`define CRG_REG_GPR0 8'h08
`define CRG_REG_PAIR0 8'h10
`define CRG_REG_STATUS 8'h18
`define CRG_REG_CTRL 8'h19
`define CRG_SFR_RO_LO 8'h10
`define CRG_SFR_RO_HI 8'h1B
`endif

/* rtl/crg_pkg.sv */
package crg_pkg;
  typedef enum logic [1:0] {
    CRG_ST_RESET = 2'b00,
    CRG_ST_VEC_LO = 2'b01,
    CRG_ST_VEC_HI = 2'b11,
    CRG_ST_RUN = 2'b10
  } crg_state_t;

  typedef enum logic [3:0] {
    CRG_OP_NONE = 4'h0,
    CRG_OP_SEQ = 4'h1,
    CRG_OP_BR_IMM = 4'h2,
    CRG_OP_BR_REG = 4'h3,
    CRG_OP_PUSH = 4'h4,
    CRG_OP_POP = 4'h5,
    CRG_OP_PUSH_FLAGS = 4'h6,
    CRG_OP_POP_FLAGS = 4'h7,
    CRG_OP_IRQ_RETURN = 4'h8,
    CRG_OP_MASK_ALL = 4'h9,
    CRG_OP_UNMASK = 4'hA
  } crg_op_t;

  typedef enum logic [2:0] {
    CRG_ALU_NONE = 3'h0,
    CRG_ALU_ADD = 3'h1,
    CRG_ALU_SUB = 3'h2,
    CRG_ALU_ROT = 3'h3,
    CRG_ALU_BIT = 3'h4,
    CRG_ALU_LOGIC = 3'h5
  } crg_alu_t;

  typedef struct packed {
    crg_op_t op;
    logic [2:0] len;
    logic [15:0] target;
    logic [7:0] data;
  } crg_cmd_t;

  typedef struct packed {
    crg_alu_t kind;
    logic [7:0] result;
    logic carry;
    logic nib_carry;
  } crg_alu_res_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } crg_bus_t;
endpackage

/* verif/crg_mem_model.sv */
`timescale 1ns/1ps
// memory behind the register block: vector bytes, stack ram, write capture
module crg_mem_model #(
  parameter logic [15:0] RESET_TARGET = 16'h1234
) (
  input wire logic i_clk,
  input wire logic [15:0] i_mem_addr,
  input wire logic i_mem_rd,
  input wire logic i_mem_wr,
  input wire logic [7:0] i_mem_wdata,
  output logic [7:0] o_mem_rdata
);
  logic [7:0] mem [0:65535];
  logic wr_pend_q = 1'b0;
  logic [15:0] wr_addr_q = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // reset vector stored low byte at the even address, high byte at the odd one
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'h00;
    end
    mem[16'h0000] = RESET_TARGET[7:0];
    mem[16'h0001] = RESET_TARGET[15:8];
    o_mem_rdata = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // write data trails its strobe by one cycle, so the address is held over
  always @(posedge i_clk) begin
    if (wr_pend_q) begin
      mem[wr_addr_q] <= i_mem_wdata;
    end
    wr_pend_q <= i_mem_wr;
    wr_addr_q <= i_mem_addr;
  end

  // read data stands one cycle only; otherwise toggles so stale data never matches
  always @(posedge i_clk) begin
    if (i_mem_rd) begin
      o_mem_rdata <= mem[i_mem_addr];
    end else begin
      o_mem_rdata <= ~o_mem_rdata;
    end
  end
endmodule

/* verif/tb.sv */
`timescale 1ns/1ps
`include "crg_params.svh"
module tb;
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  crg_pkg::crg_cmd_t i_cmd = '0;
  crg_pkg::crg_alu_res_t i_alu = '0;
  logic [2:0] i_reg_sel = 3'h0;
  logic i_reg_we = 1'b0;
  logic [7:0] i_reg_wdata = 8'h00;
  logic [7:0] i_irq_req = 8'h00;
  logic [7:0] i_irq_mask = 8'hFF;
  logic i_nmi_req = 1'b0;
  logic [15:0] i_irq_vector = 16'h0400;
  logic [15:0] i_daddr = 16'h0000;
  logic [7:0] i_addr = 8'h00;
  logic [15:0] i_wdata = 16'h0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [7:0] i_mem_rdata;
  logic [15:0] o_mem_addr, o_fetch_ptr, o_stack_ptr, o_rdata;
  logic o_mem_rd, o_mem_wr, o_irq_ack, o_ready, o_stack_fault, o_daddr_sfr, o_daddr_special;
  logic [7:0] o_mem_wdata, o_flags, o_reg_rdata;
  int failures = 0;
  int checked = 0;
  int cyc = 0;
  int acks = 0;
  int faults = 0;
  logic [15:0] dec_a [5] = '{16'hFCFF, 16'hFD00, 16'hFEFF, 16'hFF00, 16'hFFFF};
  logic [1:0] dec_e [5] = '{2'b00, 2'b01, 2'b01, 2'b11, 2'b11};

  crg_cpu_regs #(.LARGE_RAM(1'b1), .NUM_IRQ(8)) u_crg_cpu_regs (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_cmd(i_cmd), .i_alu(i_alu),
    .i_reg_sel(i_reg_sel), .i_reg_we(i_reg_we), .i_reg_wdata(i_reg_wdata),
    .i_mem_rdata(i_mem_rdata), .i_irq_req(i_irq_req), .i_irq_mask(i_irq_mask),
    .i_nmi_req(i_nmi_req), .i_irq_vector(i_irq_vector), .o_mem_addr(o_mem_addr),
    .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr), .o_mem_wdata(o_mem_wdata),
    .o_irq_ack(o_irq_ack), .o_fetch_ptr(o_fetch_ptr), .o_flags(o_flags),
    .o_stack_ptr(o_stack_ptr), .o_reg_rdata(o_reg_rdata), .o_ready(o_ready),
    .o_stack_fault(o_stack_fault), .i_daddr(i_daddr), .o_daddr_sfr(o_daddr_sfr),
    .o_daddr_special(o_daddr_special), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata));

  crg_mem_model #(.RESET_TARGET(16'h1234)) u_crg_mem_model (
    .i_clk(i_clk), .i_mem_addr(o_mem_addr), .i_mem_rd(o_mem_rd), .i_mem_wr(o_mem_wr),
    .i_mem_wdata(o_mem_wdata), .o_mem_rdata(i_mem_rdata));

  ////////////////////////////////////////////////////////////////////////////
  // clock, acknowledge counter and hang guard
  always #5 i_clk = ~i_clk;

  always @(posedge i_clk) begin
    if (o_irq_ack === 1'b1) begin
      acks <= acks + 1;
    end
    // the fault flag is high one cycle per faulting stack access, so it is counted as it passes
    if (o_stack_fault === 1'b1) begin
      faults <= faults + 1;
    end
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      wrap_up();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    if (failures == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // register port: read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [15:0] exp, input string nm);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    chk(nm, exp, o_rdata);
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  // one instruction step, offered once ready is seen or, as a failure, after 50 cycles, then time to finish
  task automatic cmd(input crg_pkg::crg_op_t op, input logic [2:0] len,
                     input logic [15:0] tgt, input logic [7:0] dat,
                     input crg_pkg::crg_alu_t k, input logic [7:0] res, input logic [1:0] cc);
    int n;
    n = 0;
    while (o_ready !== 1'b1 && n < 50) begin
      @(negedge i_clk);
      n++;
    end
    if (n == 50) begin
      chk("ready", 16'h0001, 16'h0000);
    end
    @(posedge i_clk);
    i_cmd <= '{op: op, len: len, target: tgt, data: dat};
    i_alu <= '{kind: k, result: res, carry: cc[1], nib_carry: cc[0]};
    @(posedge i_clk);
    i_cmd <= '0;
    i_alu <= '0;
    repeat (8) @(negedge i_clk);
  endtask

  task automatic op(input crg_pkg::crg_op_t o, input logic [7:0] dat);
    cmd(o, 3'h0, 16'h0000, dat, crg_pkg::CRG_ALU_NONE, 8'h00, 2'b00);
  endtask

  task automatic alu(input crg_pkg::crg_alu_t k, input logic [7:0] res, input logic [1:0] cc);
    cmd(crg_pkg::CRG_OP_SEQ, 3'h1, 16'h0000, 8'h00, k, res, cc);
  endtask

  // raise a request, drop it once taken or after 12 cycles, and count the acknowledges seen
  task automatic irq_try(input logic nmi, input logic [7:0] msk, input int want);
    int a0;
    a0 = acks;
    @(posedge i_clk);
    i_nmi_req <= nmi;
    i_irq_req <= 8'h08;
    i_irq_mask <= msk;
    for (int n = 0; n < 12 && acks == a0; n++) begin
      @(negedge i_clk);
    end
    @(posedge i_clk);
    i_nmi_req <= 1'b0;
    i_irq_req <= 8'h00;
    repeat (10) @(negedge i_clk);
    chk("irq acks", 16'(want), 16'(acks - a0));
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (20) @(posedge i_clk);
    i_resetn <= 1'b1;
    repeat (8) @(negedge i_clk);
    chk("fetch after reset", 16'h1234, o_fetch_ptr);
    rd(`CRG_REG_FLAGS, 16'h0002, "flags reset");
    rd(`CRG_REG_FETCH, 16'h1234, "fetch reg");
    for (int i = 0; i < 8; i++) begin
      @(posedge i_clk);
      i_reg_we <= 1'b1;
      i_reg_sel <= 3'(i);
      i_reg_wdata <= 8'hA0 + 8'(i);
    end
    @(posedge i_clk);
    i_reg_we <= 1'b0;
    i_reg_sel <= 3'h5;
    repeat (2) @(negedge i_clk);
    chk("gpr port", 16'h00A5, {8'h00, o_reg_rdata});
    for (int i = 0; i < 8; i++) begin
      rd(`CRG_REG_GPR0 + 8'(i), {8'h00, 8'hA0 + 8'(i)}, "gpr");
    end
    for (int i = 0; i < 4; i++) begin
      rd(`CRG_REG_PAIR0 + 8'(i), {8'hA1 + 8'(2 * i), 8'hA0 + 8'(2 * i)}, "pair");
    end
    cmd(crg_pkg::CRG_OP_SEQ, 3'h3, 16'h0000, 8'h00, crg_pkg::CRG_ALU_NONE, 8'h00, 2'b00);
    rd(`CRG_REG_FETCH, 16'h1237, "fetch seq3");
    alu(crg_pkg::CRG_ALU_ADD, 8'h00, 2'b11);
    rd(`CRG_REG_FLAGS, 16'h0053, "flags add zero");
    rd(`CRG_REG_FETCH, 16'h1238, "fetch seq1");
    alu(crg_pkg::CRG_ALU_SUB, 8'h7F, 2'b00);
    rd(`CRG_REG_FLAGS, 16'h0002, "flags sub");
    alu(crg_pkg::CRG_ALU_ROT, 8'h80, 2'b10);
    rd(`CRG_REG_FLAGS, 16'h0003, "flags rotate");
    alu(crg_pkg::CRG_ALU_BIT, 8'h01, 2'b00);
    rd(`CRG_REG_FLAGS, 16'h0002, "flags bit");
    op(crg_pkg::CRG_OP_UNMASK, 8'h00);
    rd(`CRG_REG_FLAGS, 16'h0082, "flags unmask");
    op(crg_pkg::CRG_OP_MASK_ALL, 8'h00);
    rd(`CRG_REG_FLAGS, 16'h0002, "flags mask");
    cmd(crg_pkg::CRG_OP_BR_IMM, 3'h3, 16'h2000, 8'h00, crg_pkg::CRG_ALU_NONE, 8'h00, 2'b00);
    rd(`CRG_REG_FETCH, 16'h2000, "fetch branch");
    // stack set up by software before any stacking operation
    wr(`CRG_REG_STACK, 16'hFE80);
    rd(`CRG_REG_STACK, 16'hFE80, "stack reg");
    irq_try(1'b0, 8'h00, 0);
    irq_try(1'b1, 8'hFF, 1);
    chk("fetch nmi", 16'h0400, o_fetch_ptr);
    rd(`CRG_REG_STACK, 16'hFE7D, "stack nmi");
    chk("pushed pc hi", 16'h0020, {8'h00, u_crg_mem_model.mem[16'hFE7E]});
    chk("pushed pc lo", 16'h0000, {8'h00, u_crg_mem_model.mem[16'hFE7D]});
    op(crg_pkg::CRG_OP_IRQ_RETURN, 8'h00);
    rd(`CRG_REG_FETCH, 16'h2000, "fetch return");
    rd(`CRG_REG_STACK, 16'hFE80, "stack return");
    rd(`CRG_REG_FLAGS, 16'h0002, "flags return");
    op(crg_pkg::CRG_OP_UNMASK, 8'h00);
    irq_try(1'b0, 8'hFF, 0);
    irq_try(1'b0, 8'hF7, 1);
    rd(`CRG_REG_FLAGS, 16'h0002, "flags after ack");
    chk("fetch irq", 16'h0400, o_fetch_ptr);
    chk("pushed flags irq", 16'h0082, {8'h00, u_crg_mem_model.mem[16'hFE7F]});
    op(crg_pkg::CRG_OP_IRQ_RETURN, 8'h00);
    rd(`CRG_REG_FLAGS, 16'h0082, "flags irq_return_instr");
    op(crg_pkg::CRG_OP_PUSH, 8'hAB);
    chk("pushed byte", 16'h00AB, {8'h00, u_crg_mem_model.mem[16'hFE7F]});
    rd(`CRG_REG_STACK, 16'hFE7F, "stack push");
    op(crg_pkg::CRG_OP_POP, 8'h00);
    rd(`CRG_REG_STACK, 16'hFE80, "stack pop");
    chk("popped byte", 16'h00AB, {8'h00, o_reg_rdata});
    cmd(crg_pkg::CRG_OP_BR_REG, 3'h1, 16'h0000, 8'h00, crg_pkg::CRG_ALU_NONE, 8'h00, 2'b00);
    rd(`CRG_REG_FETCH, 16'hABA4, "fetch branch reg");
    op(crg_pkg::CRG_OP_MASK_ALL, 8'h00);
    op(crg_pkg::CRG_OP_PUSH_FLAGS, 8'h00);
    chk("pushed flags", 16'h0002, {8'h00, u_crg_mem_model.mem[16'hFE7F]});
    op(crg_pkg::CRG_OP_UNMASK, 8'h00);
    op(crg_pkg::CRG_OP_POP_FLAGS, 8'h00);
    rd(`CRG_REG_FLAGS, 16'h0002, "flags popped");
    rd(`CRG_REG_STACK, 16'hFE80, "stack popf");
    chk("flags out", 16'h0002, {8'h00, o_flags});
    chk("stack out", 16'hFE80, o_stack_ptr);
    // address decode across the ram and peripheral boundaries
    for (int i = 0; i < 5; i++) begin
      @(posedge i_clk);
      i_daddr <= dec_a[i];
      @(negedge i_clk);
      chk("decode", {14'h0000, dec_e[i]}, {14'h0000, o_daddr_sfr, o_daddr_special});
    end
    wr(`CRG_REG_STATUS, 16'hFFFF);
    rd(`CRG_REG_STATUS, 16'h0006, "status read-only");
    wr(8'h30, 16'hFFFF);
    rd(8'h30, 16'h0000, "unmapped");
    wr(`CRG_REG_STACK, 16'h1000);
    op(crg_pkg::CRG_OP_PUSH, 8'h55);
    chk("stack fault", 16'h0001, 16'(faults));
    wrap_up();
  end
endmodule
